//--- verilog/tcs_pkg.sv
// Package for the timer and serial port block: register map, field
// positions, mode codes, divider counts and state types.
// Assumes a single core clock at the oscillator rate.
package tcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the Avalon-MM slave (one word each)
  localparam logic [5:0] OFS_TIMER_CONTROL = 6'h00;
  localparam logic [5:0] OFS_TIMER_MODE = 6'h04;
  localparam logic [5:0] OFS_SERIAL_CONTROL = 6'h08;
  localparam logic [5:0] OFS_SERIAL_BUFFER = 6'h0c;
  localparam logic [5:0] OFS_POWER_CONTROL = 6'h10;
  localparam logic [5:0] OFS_INTERRUPT_PRIORITY = 6'h14;
  localparam logic [5:0] OFS_TIMER0_LOW = 6'h18;
  localparam logic [5:0] OFS_TIMER0_HIGH = 6'h1c;
  localparam logic [5:0] OFS_TIMER1_LOW = 6'h20;
  localparam logic [5:0] OFS_TIMER1_HIGH = 6'h24;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Timer control bit positions
  localparam int TC_T1_OVF = 7;
  localparam int TC_T1_RUN = 6;
  localparam int TC_T0_OVF = 5;
  localparam int TC_T0_RUN = 4;
  localparam int TC_X1_FLAG = 3;
  localparam int TC_X1_TYPE = 2;
  localparam int TC_X0_FLAG = 1;
  localparam int TC_X0_TYPE = 0;
  // Timer mode: timer 1 in the upper nibble, timer 0 in the lower
  localparam int TM_T1_BASE = 4;
  localparam int TM_T0_BASE = 0;
  localparam int TM_GATE = 3;
  localparam int TM_COUNT_SEL = 2;
  localparam int TM_MODE_LSB = 0;
  // Serial control bit positions
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MULTIPROC = 5;
  localparam int SC_RX_EN = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_FLAG = 1;
  localparam int SC_RX_FLAG = 0;
  localparam int PC_RATE_DOUBLE = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Mode encodings
  localparam logic [1:0] TMR_MODE_13 = 2'h0;
  localparam logic [1:0] TMR_MODE_16 = 2'h1;
  localparam logic [1:0] TMR_MODE_RELOAD = 2'h2;
  localparam logic [1:0] TMR_MODE_STOP = 2'h3;
  localparam logic [1:0] SER_MODE_SHIFT = 2'h0;
  localparam logic [1:0] SER_MODE_UART8 = 2'h1;
  localparam logic [1:0] SER_MODE_UART9F = 2'h2;
  localparam logic [1:0] SER_MODE_UART9V = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Counts: machine cycle is 12 oscillator clocks, a UART bit 16 samples
  localparam logic [3:0] MC_DIV_LAST = 4'hb;
  localparam logic [3:0] MC_HALF = 4'h6;
  localparam logic [3:0] SAMPLE_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [1:0] FIX_DIV_LAST = 2'h3;
  localparam logic [4:0] PRESCALE_LAST = 5'h1f;
  localparam logic [3:0] SHIFT_BITS = 4'h8;
  localparam logic [3:0] UART8_BITS = 4'ha;
  localparam logic [3:0] UART9_BITS = 4'hb;
  localparam logic [3:0] TX_STOP_LEFT = 4'h1;
  localparam logic [3:0] RX_STOP8 = 4'h8;
  localparam logic [3:0] RX_STOP9 = 4'h9;

  // Synchronised pin indices
  localparam int PIN_X0 = 0;
  localparam int PIN_X1 = 1;
  localparam int PIN_T0 = 2;
  localparam int PIN_T1 = 3;
  localparam int PIN_RXD = 4;
  localparam int PIN_COUNT = 5;

  typedef enum logic {TX_IDLE, TX_SHIFT} tcs_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SHIFT0} tcs_rx_e;

endpackage

//--- verilog/tcs_sync2.sv
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes the pins are asynchronous to core_clk; only stage two is read.
`timescale 1ns/100ps
module tcs_sync2
  import tcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [PIN_COUNT-1:0] pin_async,
  output logic [PIN_COUNT-1:0] pin_sync
);
  logic [PIN_COUNT-1:0] meta_r;
  logic [PIN_COUNT-1:0] sync_r;

  // Idle-high reset so no false edge is seen after release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= pin_async;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;
endmodule // tcs_sync2

//--- verilog/tcs_timer.sv
// One timer/counter: 13-bit, 16-bit, 8-bit auto-reload or stopped.
// Assumes tick and event_fall are one-cycle pulses on core_clk.
`timescale 1ns/100ps
module tcs_timer
  import tcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic event_fall,
  input wire logic gate,
  input wire logic count_sel,
  input wire logic [1:0] mode,
  input wire logic run,
  input wire logic pin_high,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  output logic [7:0] count_lo,
  output logic [7:0] count_hi,
  output logic ovf
);
  logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt;
  logic ovf_r, ovf_nxt;
  logic [15:0] full_inc;

  // Gate pin qualifies the run bit; source is machine tick or pin edge
  wire enable = run & (~gate | pin_high);
  wire step = enable & (count_sel ? event_fall : tick);
  assign full_inc = {hi_r, lo_r} + 16'h0001;

  // Next count per mode; a software write wins over counting
  always_comb begin
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    ovf_nxt = 1'b0;
    if (step) begin
      unique case (mode)
        TMR_MODE_13: begin
          if (lo_r[4:0] == PRESCALE_LAST) begin
            lo_nxt = {lo_r[7:5], 5'h00};
            hi_nxt = hi_r + 8'h01;
            ovf_nxt = (hi_r == IDLE_BYTE);
          end else begin
            lo_nxt = lo_r + 8'h01;
          end
        end
        TMR_MODE_16: begin
          {hi_nxt, lo_nxt} = full_inc;
          ovf_nxt = ({hi_r, lo_r} == {IDLE_BYTE, IDLE_BYTE});
        end
        TMR_MODE_RELOAD: begin
          lo_nxt = (lo_r == IDLE_BYTE) ? hi_r : lo_r + 8'h01;
          ovf_nxt = (lo_r == IDLE_BYTE);
        end
        TMR_MODE_STOP: begin
          lo_nxt = lo_r;
        end
      endcase
    end
    if (wr_lo) begin
      lo_nxt = wdata;
    end
    if (wr_hi) begin
      hi_nxt = wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lo_r <= RST_BYTE;
      hi_r <= RST_BYTE;
      ovf_r <= 1'b0;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign count_lo = lo_r;
  assign count_hi = hi_r;
  assign ovf = ovf_r;
endmodule // tcs_timer

//--- verilog/tcs_timer_serial.sv
// Two timer/counters, external interrupt flags and a four-mode serial
// port, with control registers on an Avalon-MM slave.
// Assumes pins are asynchronous; vector acks come from the core clock.
`timescale 1ns/100ps
module tcs_timer_serial
  import tcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_irq_pin_0,
  input wire logic ext_irq_pin_1,
  input wire logic count_pin_0,
  input wire logic count_pin_1,
  input wire logic vector_ack_ext0,
  input wire logic vector_ack_timer0,
  input wire logic vector_ack_ext1,
  input wire logic vector_ack_timer1,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic ext_irq0_flag,
  output logic ext_irq1_flag,
  output logic tx_irq_flag,
  output logic rx_irq_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic wait_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] tctl_r, tctl_nxt, tmode_r, sctl_r, sctl_nxt;
  logic [7:0] pctl_r, prio_r, rbuf_r, rbuf_nxt;
  logic [3:0] mc_div_r;
  logic [1:0] fix_div_r;
  logic half_r, half_nxt;
  logic [PIN_COUNT-1:0] pins_s, pins_prev_r;
  logic [7:0] t0_lo, t0_hi, t1_lo, t1_hi;
  logic t0_ovf, t1_ovf;
  tcs_tx_e tx_st_r, tx_st_nxt;
  tcs_rx_e rx_st_r, rx_st_nxt;
  logic [10:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_left_r, tx_left_nxt, tx_sub_r, tx_sub_nxt;
  logic [8:0] rx_sh_r, rx_sh_nxt;
  logic [3:0] rx_cnt_r, rx_cnt_nxt, rx_sub_r, rx_sub_nxt;
  logic ti_set, ri_set, rb8_load, rb8_val;
  logic txd_r, txd_nxt, rxd_out_r, rxd_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon decode: one wait state, then the access completes
  wire req = avs_read | avs_write;
  wire done = req & ~wait_r;
  wire wr_lane = done & avs_write & avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_tctl = wr_lane & (avs_address == OFS_TIMER_CONTROL);
  wire wr_tmode = wr_lane & (avs_address == OFS_TIMER_MODE);
  wire wr_sctl = wr_lane & (avs_address == OFS_SERIAL_CONTROL);
  wire wr_sbuf = wr_lane & (avs_address == OFS_SERIAL_BUFFER);
  wire wr_pctl = wr_lane & (avs_address == OFS_POWER_CONTROL);
  wire wr_prio = wr_lane & (avs_address == OFS_INTERRUPT_PRIORITY);
  wire wr_t0lo = wr_lane & (avs_address == OFS_TIMER0_LOW);
  wire wr_t0hi = wr_lane & (avs_address == OFS_TIMER0_HIGH);
  wire wr_t1lo = wr_lane & (avs_address == OFS_TIMER1_LOW);
  wire wr_t1hi = wr_lane & (avs_address == OFS_TIMER1_HIGH);

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (avs_address)
      OFS_TIMER_CONTROL: rdata_nxt[7:0] = tctl_r;
      OFS_TIMER_MODE: rdata_nxt[7:0] = tmode_r;
      OFS_SERIAL_CONTROL: rdata_nxt[7:0] = sctl_r;
      OFS_SERIAL_BUFFER: rdata_nxt[7:0] = rbuf_r;
      OFS_POWER_CONTROL: rdata_nxt[7:0] = pctl_r;
      OFS_INTERRUPT_PRIORITY: rdata_nxt[7:0] = prio_r;
      OFS_TIMER0_LOW: rdata_nxt[7:0] = t0_lo;
      OFS_TIMER0_HIGH: rdata_nxt[7:0] = t0_hi;
      OFS_TIMER1_LOW: rdata_nxt[7:0] = t1_lo;
      OFS_TIMER1_HIGH: rdata_nxt[7:0] = t1_hi;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Wait drops for one cycle per request; read data sampled on the way
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (req & wait_r) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and clock division
  tcs_sync2 u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_async({rxd_in, count_pin_1, count_pin_0, ext_irq_pin_1,
                ext_irq_pin_0}),
    .pin_sync(pins_s)
  );

  // Falling edges seen on synchronised pins only
  wire [PIN_COUNT-1:0] pin_fall = pins_prev_r & ~pins_s;
  wire mc_tick = (mc_div_r == MC_DIV_LAST);
  wire rate_double = pctl_r[PC_RATE_DOUBLE];
  wire [1:0] smode = {sctl_r[SC_MODE_HI], sctl_r[SC_MODE_LO]};
  wire mode0 = (smode == SER_MODE_SHIFT);
  wire mode1 = (smode == SER_MODE_UART8);
  wire mode23 = smode[1];
  // Mode 2 samples at osc/2 or osc/4, giving osc/32 or osc/64 per bit
  wire fix_tick = rate_double ? fix_div_r[0] : (fix_div_r == FIX_DIV_LAST);
  // Modes 1, 3 sample on timer 1 overflow, halved unless doubled
  wire var_tick = t1_ovf & (rate_double | half_r);
  wire samp_tick = (smode == SER_MODE_UART9F) ? fix_tick : var_tick;
  assign half_nxt = t1_ovf ? ~half_r : half_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mc_div_r <= 4'h0;
      fix_div_r <= 2'h0;
      half_r <= 1'b0;
      pins_prev_r <= '1;
    end else begin
      mc_div_r <= mc_tick ? 4'h0 : mc_div_r + 4'h1;
      fix_div_r <= fix_div_r + 2'h1;
      half_r <= half_nxt;
      pins_prev_r <= pins_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers; the mode byte holds both timers, written as one value
  tcs_timer u_timer0 (
    .core_clk(core_clk),
    .rst(rst),
    .tick(mc_tick),
    .event_fall(pin_fall[PIN_T0]),
    .gate(tmode_r[TM_T0_BASE+TM_GATE]),
    .count_sel(tmode_r[TM_T0_BASE+TM_COUNT_SEL]),
    .mode(tmode_r[TM_T0_BASE+TM_MODE_LSB +: 2]),
    .run(tctl_r[TC_T0_RUN]),
    .pin_high(pins_s[PIN_X0]),
    .wr_lo(wr_t0lo),
    .wr_hi(wr_t0hi),
    .wdata(wd),
    .count_lo(t0_lo),
    .count_hi(t0_hi),
    .ovf(t0_ovf)
  );

  tcs_timer u_timer1 (
    .core_clk(core_clk),
    .rst(rst),
    .tick(mc_tick),
    .event_fall(pin_fall[PIN_T1]),
    .gate(tmode_r[TM_T1_BASE+TM_GATE]),
    .count_sel(tmode_r[TM_T1_BASE+TM_COUNT_SEL]),
    .mode(tmode_r[TM_T1_BASE+TM_MODE_LSB +: 2]),
    .run(tctl_r[TC_T1_RUN]),
    .pin_high(pins_s[PIN_X1]),
    .wr_lo(wr_t1lo),
    .wr_hi(wr_t1hi),
    .wdata(wd),
    .count_lo(t1_lo),
    .count_hi(t1_hi),
    .ovf(t1_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over a software write or a vector clear
  wire x0_hit = tctl_r[TC_X0_TYPE] ? pin_fall[PIN_X0] : ~pins_s[PIN_X0];
  wire x1_hit = tctl_r[TC_X1_TYPE] ? pin_fall[PIN_X1] : ~pins_s[PIN_X1];

  always_comb begin
    tctl_nxt = wr_tctl ? wd : tctl_r;
    if (!wr_tctl) begin
      tctl_nxt[TC_T0_OVF] = tctl_r[TC_T0_OVF] & ~vector_ack_timer0;
      tctl_nxt[TC_T1_OVF] = tctl_r[TC_T1_OVF] & ~vector_ack_timer1;
      tctl_nxt[TC_X0_FLAG] = tctl_r[TC_X0_FLAG] & ~vector_ack_ext0;
      tctl_nxt[TC_X1_FLAG] = tctl_r[TC_X1_FLAG] & ~vector_ack_ext1;
    end
    tctl_nxt[TC_T0_OVF] = tctl_nxt[TC_T0_OVF] | t0_ovf;
    tctl_nxt[TC_T1_OVF] = tctl_nxt[TC_T1_OVF] | t1_ovf;
    tctl_nxt[TC_X0_FLAG] = tctl_nxt[TC_X0_FLAG] | x0_hit;
    tctl_nxt[TC_X1_FLAG] = tctl_nxt[TC_X1_FLAG] | x1_hit;
  end

  // Serial flags are only cleared by software
  always_comb begin
    sctl_nxt = wr_sctl ? wd : sctl_r;
    if (rb8_load) begin
      sctl_nxt[SC_RX_NINTH] = rb8_val;
    end
    sctl_nxt[SC_TX_FLAG] = sctl_nxt[SC_TX_FLAG] | ti_set;
    sctl_nxt[SC_RX_FLAG] = sctl_nxt[SC_RX_FLAG] | ri_set;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tctl_r <= RST_BYTE;
      tmode_r <= RST_BYTE;
      sctl_r <= RST_BYTE;
      pctl_r <= RST_BYTE;
      prio_r <= RST_BYTE;
      rbuf_r <= RST_BYTE;
    end else begin
      tctl_r <= tctl_nxt;
      tmode_r <= wr_tmode ? wd : tmode_r;
      sctl_r <= sctl_nxt;
      pctl_r <= wr_pctl ? wd : pctl_r;
      prio_r <= wr_prio ? wd : prio_r;
      rbuf_r <= rbuf_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter; a buffer write while busy is dropped, no queue exists
  wire tx_bit_end = samp_tick & (tx_sub_r == SAMPLE_LAST);
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_left_nxt = tx_left_r;
    tx_sub_nxt = tx_sub_r;
    ti_set = 1'b0;
    unique case (tx_st_r)
      TX_IDLE: begin
        if (wr_sbuf) begin
          tx_st_nxt = TX_SHIFT;
          tx_sub_nxt = 4'h0;
          if (mode0) begin
            tx_sh_nxt = {3'h7, wd};
            tx_left_nxt = SHIFT_BITS;
          end else if (mode23) begin
            tx_sh_nxt = {1'b1, sctl_r[SC_TX_NINTH], wd, 1'b0};
            tx_left_nxt = UART9_BITS;
          end else begin
            tx_sh_nxt = {2'h3, wd, 1'b0};
            tx_left_nxt = UART8_BITS;
          end
        end
      end
      TX_SHIFT: begin
        if (mode0 & mc_tick) begin
          tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
          tx_left_nxt = tx_left_r - 4'h1;
          ti_set = (tx_left_r == TX_STOP_LEFT);
          tx_st_nxt = (tx_left_r == TX_STOP_LEFT) ? TX_IDLE : TX_SHIFT;
        end else if (!mode0 & samp_tick) begin
          tx_sub_nxt = tx_sub_r + 4'h1;
          if (tx_bit_end) begin
            tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
            tx_left_nxt = tx_left_r - 4'h1;
            // Flag as the stop bit begins
            ti_set = (tx_left_r == TX_STOP_LEFT + 4'h1);
            tx_st_nxt = (tx_left_r == TX_STOP_LEFT) ? TX_IDLE : TX_SHIFT;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver; clearing the enable aborts a frame in progress
  wire ren = sctl_r[SC_RX_EN];
  wire rxd_s = pins_s[PIN_RXD];
  wire rx_mid = samp_tick & (rx_sub_r == SAMPLE_MID);
  wire [3:0] rx_stop = mode1 ? RX_STOP8 : RX_STOP9;
  wire [7:0] rx_byte = mode1 ? rx_sh_r[8:1] : rx_sh_r[7:0];
  wire rx_ninth = mode1 ? rxd_s : rx_sh_r[8];
  wire mp_on = sctl_r[SC_MULTIPROC] & mode23;
  // Filtered frames and frames arriving with the flag still set are lost
  wire rx_accept = ~sctl_r[SC_RX_FLAG] & (~mp_on | rx_ninth)
                   & ~(mode1 & sctl_r[SC_MULTIPROC] & ~rxd_s);

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_sub_nxt = samp_tick ? rx_sub_r + 4'h1 : rx_sub_r;
    rbuf_nxt = rbuf_r;
    ri_set = 1'b0;
    rb8_load = 1'b0;
    rb8_val = 1'b0;
    unique case (rx_st_r)
      RX_IDLE: begin
        rx_cnt_nxt = 4'h0;
        rx_sub_nxt = 4'h0;
        if (ren & mode0 & ~sctl_r[SC_RX_FLAG]) begin
          rx_st_nxt = RX_SHIFT0;
        end else if (ren & ~mode0 & pin_fall[PIN_RXD]) begin
          rx_st_nxt = RX_START;
        end
      end
      RX_START: begin
        if (rx_mid) begin
          rx_st_nxt = rxd_s ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_mid) begin
          rx_sh_nxt = {rxd_s, rx_sh_r[8:1]};
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          if (rx_cnt_r == rx_stop) begin
            // Halfway through the stop bit
            rx_st_nxt = RX_IDLE;
            rx_sh_nxt = rx_sh_r;
            ri_set = rx_accept;
            rbuf_nxt = rx_accept ? rx_byte : rbuf_r;
            rb8_load = rx_accept & (mode23 | ~sctl_r[SC_MULTIPROC]);
            rb8_val = rx_ninth;
          end
        end
      end
      RX_SHIFT0: begin
        if (mc_tick) begin
          rx_sh_nxt = {rxd_s, rx_sh_r[8:1]};
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          if (rx_cnt_r == SHIFT_BITS - 4'h1) begin
            rx_st_nxt = RX_IDLE;
            ri_set = 1'b1;
            rbuf_nxt = {rxd_s, rx_sh_r[8:2]};
          end
        end
      end
    endcase
    if (!ren) begin
      rx_st_nxt = RX_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line drivers: mode 0 clocks on txd and shifts data on rxd
  wire tx_busy = (tx_st_r == TX_SHIFT);
  wire shift_clk_on = (tx_busy & mode0) | (rx_st_r == RX_SHIFT0);
  always_comb begin
    txd_nxt = 1'b1;
    if (shift_clk_on) begin
      txd_nxt = (mc_div_r >= MC_HALF);
    end else if (tx_busy) begin
      txd_nxt = tx_sh_r[0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= '1;
      tx_left_r <= 4'h0;
      tx_sub_r <= 4'h0;
      rx_st_r <= RX_IDLE;
      rx_sh_r <= '0;
      rx_cnt_r <= 4'h0;
      rx_sub_r <= 4'h0;
      txd_r <= 1'b1;
      rxd_out_r <= 1'b1;
      rxd_oe_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_left_r <= tx_left_nxt;
      tx_sub_r <= tx_sub_nxt;
      rx_st_r <= rx_st_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_sub_r <= rx_sub_nxt;
      txd_r <= txd_nxt;
      rxd_out_r <= tx_sh_r[0];
      rxd_oe_r <= tx_busy & mode0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign txd = txd_r;
  assign rxd_out = rxd_out_r;
  assign rxd_oe = rxd_oe_r;
  assign timer0_overflow_flag = tctl_r[TC_T0_OVF];
  assign timer1_overflow_flag = tctl_r[TC_T1_OVF];
  assign ext_irq0_flag = tctl_r[TC_X0_FLAG];
  assign ext_irq1_flag = tctl_r[TC_X1_FLAG];
  assign tx_irq_flag = sctl_r[SC_TX_FLAG];
  assign rx_irq_flag = sctl_r[SC_RX_FLAG];

endmodule // tcs_timer_serial

//--- sim/tcs_timer_serial_properties.sv
// Checker for bus timing and flag set and clear rules at the top ports.
// Assumes it is bound to tcs_timer_serial.
`timescale 1ns/100ps
module tcs_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic ext_irq_pin_0,
  input wire logic vector_ack_ext0,
  input wire logic vector_ack_timer0,
  input wire logic timer0_overflow_flag,
  input wire logic ext_irq0_flag,
  input wire logic tx_irq_flag,
  input wire logic rx_irq_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // A request still waiting for its answer
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_req |-> ##[1:2] !avs_waitrequest)
    else $error("bus answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_rdata_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  // Flags fall only on a vector ack or a software write
  a_t0_clear: assert property (
    $fell(timer0_overflow_flag) |-> $past(vector_ack_timer0)
      || $past(avs_write)) else $error("timer flag lost");
  a_ext0_clear: assert property (
    $fell(ext_irq0_flag) |-> $past(vector_ack_ext0) || $past(avs_write))
    else $error("ext flag lost");
  a_ext0_cause: assert property (
    $rose(ext_irq0_flag) |-> $past(avs_write) || !$past(ext_irq_pin_0, 2)
      || !$past(ext_irq_pin_0, 3) || !$past(ext_irq_pin_0, 4))
    else $error("ext flag without pin low");
  a_tx_sw_clear: assert property (
    $fell(tx_irq_flag) |-> $past(avs_write)) else $error("tx flag lost");
  a_rx_sw_clear: assert property (
    $fell(rx_irq_flag) |-> $past(avs_write)) else $error("rx flag lost");
endmodule // tcs_props
bind tcs_timer_serial tcs_props u_props (.core_clk, .rst, .avs_read,
  .avs_write, .avs_waitrequest, .avs_readdata, .ext_irq_pin_0,
  .vector_ack_ext0, .vector_ack_timer0, .timer0_overflow_flag,
  .ext_irq0_flag, .tx_irq_flag, .rx_irq_flag);

//--- sim/tcs_peer.sv
// Remote serial peer: sends frames on the receive line, captures txd.
// Assumes the bench sets bit_clk to the active bit time in clocks.
`timescale 1ns/100ps
module tcs_peer (
  input wire logic core_clk,
  input wire logic txd,
  output logic rxd
);
  int bit_clk = 32;
  initial rxd = 1'h1; // Line idles high, driven by the peer
  // Start, eight data bits LSB first, ninth bit, stop
  task automatic send(input logic [8:0] d);
    logic [10:0] f;
    f = {1'h1, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (bit_clk) @(posedge core_clk);
    end
  endtask
  // Samples mid-bit, so edge phase against ticks does not matter
  task automatic recv(output logic [9:0] d);
    while (txd !== 1'h0) @(posedge core_clk);
    repeat (bit_clk / 2) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_clk) @(posedge core_clk);
      d[i] = txd;
    end
  endtask
endmodule // tcs_peer

//--- sim/tcs_timer_serial_tb.sv
// Bench for the timer and serial block: bus tasks, timer and UART tests.
// Assumes the peer model and the checker are compiled beforehand.
`timescale 1ns/100ps
module tcs_timer_serial_tb;
  import tcs_pkg::*;
  logic core_clk = 0, rst = 1, avs_read = 0, avs_write = 0, wreq;
  logic [5:0] avs_address = 6'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] be = 4'h1;
  logic x0 = 1, x1 = 1, c0 = 1, c1 = 1, ax0 = 0, at0 = 0, z = 0;
  logic rxd_out, rxd_oe, txd, prx, f0, f1, e0, e1, ti, ri;
  logic [7:0] q;
  logic [9:0] fr;
  int n_fail = 0, n_compared = 0;
  wire rxd = rxd_oe ? rxd_out : prx; // Level from the DUT while rxd_oe is high, else from the peer
  tcs_timer_serial dut (.core_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(be), .avs_readdata,
    .avs_waitrequest(wreq), .ext_irq_pin_0(x0), .ext_irq_pin_1(x1),
    .count_pin_0(c0), .count_pin_1(c1), .vector_ack_ext0(ax0),
    .vector_ack_timer0(at0), .vector_ack_ext1(z), .vector_ack_timer1(z),
    .rxd_in(rxd), .rxd_out, .rxd_oe, .txd, .timer0_overflow_flag(f0),
    .timer1_overflow_flag(f1), .ext_irq0_flag(e0), .ext_irq1_flag(e1),
    .tx_irq_flag(ti), .rx_irq_flag(ri));
  tcs_peer peer (.core_clk, .txd, .rxd(prx));
  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [9:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (wreq !== 1'h0);
    q = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic rd(input string nm, input logic [5:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h0);
    chk(nm, {2'h0, q}, {2'h0, e});
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog: the tests need well under a tenth of this span
  initial begin
    #1000000;
    n_fail++;
    give_verdict;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    rd("timer_control", OFS_TIMER_CONTROL, 8'h00);
    rd("serial_control", OFS_SERIAL_CONTROL, 8'h00);
    bus(1'h1, OFS_INTERRUPT_PRIORITY, 8'h15);
    rd("prio", OFS_INTERRUPT_PRIORITY, 8'h15);
    rd("hole", 6'h28, 8'h00);
    $display("test registers done");
    bus(1'h1, OFS_TIMER_MODE, 8'h59);
    bus(1'h1, OFS_TIMER_CONTROL, 8'h05);
    x0 <= 1'h0;
    bus(1'h1, OFS_TIMER_CONTROL, 8'h55);
    repeat (3) begin
      c1 <= 1'h0;
      repeat (4) @(posedge core_clk);
      c1 <= 1'h1;
      repeat (4) @(posedge core_clk);
    end
    repeat (100) @(posedge core_clk);
    rd("t0 gated", OFS_TIMER0_LOW, 8'h00);
    rd("t1 events", OFS_TIMER1_LOW, 8'h03);
    chk("ext0 set", {9'h0, e0}, 10'h1);
    ax0 <= 1'h1;
    @(posedge core_clk);
    ax0 <= 1'h0;
    @(posedge core_clk);
    chk("ext0 clear", {9'h0, e0}, 10'h0);
    x0 <= 1'h1;
    repeat (120) @(posedge core_clk);
    bus(1'h1, OFS_TIMER_CONTROL, 8'h45);
    bus(1'h0, OFS_TIMER0_LOW, 8'h0);
    chk("t0 run", {9'h0, q >= 8'h09 && q <= 8'h0b}, 10'h1);
    repeat (30) @(posedge core_clk);
    rd("t0 off", OFS_TIMER0_LOW, q);
    $display("test gate and events done");
    bus(1'h1, OFS_TIMER_MODE, 8'h22);
    bus(1'h1, OFS_TIMER0_HIGH, 8'hf0);
    bus(1'h1, OFS_TIMER0_LOW, 8'hfe);
    bus(1'h1, OFS_TIMER1_HIGH, 8'hff);
    bus(1'h1, OFS_TIMER1_LOW, 8'hff);
    bus(1'h1, OFS_TIMER_CONTROL, 8'h50);
    while (f0 !== 1'h1) @(posedge core_clk);
    rd("reload", OFS_TIMER0_LOW, 8'hf0);
    rd("ovf flags", OFS_TIMER_CONTROL, 8'hf0);
    at0 <= 1'h1;
    @(posedge core_clk);
    at0 <= 1'h0;
    @(posedge core_clk);
    chk("t0 flag clear", {9'h0, f0}, 10'h0);
    bus(1'h1, OFS_TIMER_MODE, 8'h23);
    bus(1'h0, OFS_TIMER0_LOW, 8'h0);
    repeat (30) @(posedge core_clk);
    rd("t0 mode stop", OFS_TIMER0_LOW, q);
    $display("test reload done");
    bus(1'h1, OFS_POWER_CONTROL, 8'h80);
    for (int m = 1; m < 4; m++) begin
      peer.bit_clk = (m == 2) ? 32 : 192;
      bus(1'h1, OFS_SERIAL_CONTROL, {m[1:0], 6'h08});
      bus(1'h1, OFS_SERIAL_BUFFER, 8'ha5);
      peer.recv(fr);
      chk("tx frame", fr, 10'h3a5);
      chk("tx flag", {9'h0, ti}, 10'h1);
      // Wait one bit so the frame ends before the next write
      repeat (peer.bit_clk) @(posedge core_clk);
    end
    bus(1'h1, OFS_SERIAL_CONTROL, 8'h00);
    bus(1'h1, OFS_SERIAL_BUFFER, 8'h80);
    repeat (2) @(posedge core_clk);
    chk("shift out", {8'h0, rxd_oe, rxd_out}, 10'h2);
    repeat (110) @(posedge core_clk);
    chk("shift end", {8'h0, ti, rxd_oe}, 10'h2);
    peer.bit_clk = 32;
    bus(1'h1, OFS_SERIAL_CONTROL, 8'hb0);
    peer.send(9'h03c);
    chk("rx filtered", {9'h0, ri}, 10'h0);
    peer.send(9'h15a);
    chk("rx flag", {9'h0, ri}, 10'h1);
    rd("rx data", OFS_SERIAL_BUFFER, 8'h5a);
    rd("rx ninth", OFS_SERIAL_CONTROL, 8'hb5);
    bus(1'h1, OFS_SERIAL_CONTROL, 8'ha0);
    peer.send(9'h15a);
    chk("rx blocked", {9'h0, ri}, 10'h0);
    $display("test serial done");
    give_verdict;
  end
endmodule // tcs_timer_serial_tb
